// file: core/fcr_cfg.svh
`ifndef FCR_CFG_SVH
`define FCR_CFG_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define FCR_IDX_PENDING 12'hFD0
`define FCR_IDX_COMMIT 12'hFD1
`define FCR_IDX_MONITOR 12'hFD1
`define FCR_IDX_STANDBY 12'hFD2
`define FCR_IDX_PORTGATE 12'hFD3

// ----------------------------------------
// field positions
// ----------------------------------------
`define FCR_MODE_HI 7
`define FCR_MODE_LO 5
`define FCR_BOOT_BIT 4
`define FCR_AREA_HI 3
`define FCR_AREA_LO 2
`define FCR_SPARE_HI 1
`define FCR_SPARE_LO 0
`define FCR_MON_ENABLE_BIT 5
`define FCR_STANDBY_BIT 0
`define FCR_SCLK_GATE_BIT 1
`define FCR_GEN_GATE_BIT 0
`define FCR_PORTGATE_FIXED 8'h80

// ----------------------------------------
// reset values and key
// ----------------------------------------
`define FCR_PENDING_RST 8'h40
`define FCR_COMMIT_KEY 8'hD5

// ----------------------------------------
// bus answers
// ----------------------------------------
`define FCR_RESP_OKAY 2'h0
`define FCR_RESP_SLVERR 2'h2

`endif

// file: core/fcr_pkg.sv
package fcr_pkg;
   // command-sequence control codes
   typedef enum logic [2:0] {
      FCR_CMD_DISABLE = 3'b010,
      FCR_CMD_ENABLE = 3'b101
   } fcr_cmd_mode_e;

   // area-select codes
   typedef enum logic [1:0] {
      FCR_AREA_STD = 2'b00,
      FCR_AREA_CODE_TO_DATA = 2'b10
   } fcr_area_e;

   typedef logic [7:0] fcr_byte_t;
endpackage : fcr_pkg

// file: core/fcr_axil_slave.sv
`include "fcr_cfg.svh"

// ----------------------------------------
// axi4-lite slave front end, one write and one read in flight
// ----------------------------------------
module fcr_axil_slave #(
   parameter int AW = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_fire,
   output logic [AW-1:0] wr_addr,
   output logic [7:0] wr_byte,
   output logic wr_lane0,
   input wire logic wr_err,
   output logic rd_fire,
   output logic [AW-1:0] rd_addr,
   input wire logic [7:0] rd_byte,
   input wire logic rd_err
);
   logic aw_full_r;
   logic w_full_r;
   logic ar_full_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;

   // a write is performed once both halves are held and no answer waits
   assign wr_fire = aw_full_r & w_full_r & ~s_axi_bvalid;
   assign wr_byte = wdata_r[7:0];
   assign wr_lane0 = wstrb_r[0];
   assign rd_fire = ar_full_r & ~s_axi_rvalid;

   // write address and data taken in either order, answer after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FCR_RESP_OKAY;
         wr_addr <= '0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            wr_addr <= s_axi_awaddr;
            aw_full_r <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            w_full_r <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? `FCR_RESP_SLVERR : `FCR_RESP_OKAY;
         end
         // ready again only once the answer is gone: one write at a time
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // read channel: answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_full_r <= 1'b0;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `FCR_RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         rd_addr <= '0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            rd_addr <= s_axi_araddr;
            ar_full_r <= 1'b1;
            s_axi_arready <= 1'b0;
         end
         if (rd_fire) begin
            ar_full_r <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_err ? `FCR_RESP_SLVERR : `FCR_RESP_OKAY;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule : fcr_axil_slave

// file: core/fcr_top.sv
// Design decision made here: register access over AXI4-Lite.
`include "fcr_cfg.svh"

module fcr_top #(
   parameter int AW = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_mode,
   input wire logic exec_from_ram,
   input wire logic flash_access,
   input wire logic irq_taken,
   input wire logic vector_in_ram,
   input wire logic cmd_strobe,
   output logic cmd_strobe_pass,
   output logic flash_cmd_enable,
   output logic boot_rom_shown,
   output logic area_remap,
   output logic [1:0] spare_select,
   output logic standby_bit,
   output logic standby_reset,
   output logic serial_clock_input_gate,
   output logic general_port_input_gate
);
   import fcr_pkg::*;

   // ----------------------------------------
   // bus front end
   // ----------------------------------------
   logic wr_fire;
   logic [AW-1:0] wr_addr;
   logic [7:0] wr_byte;
   logic wr_lane0;
   logic wr_err;
   logic rd_fire;
   logic [AW-1:0] rd_addr;
   logic [7:0] rd_byte;
   logic rd_err;

   fcr_axil_slave #(
      .AW(AW)
   ) u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_fire(wr_fire),
      .wr_addr(wr_addr),
      .wr_byte(wr_byte),
      .wr_lane0(wr_lane0),
      .wr_err(wr_err),
      .rd_fire(rd_fire),
      .rd_addr(rd_addr),
      .rd_byte(rd_byte),
      .rd_err(rd_err)
   );

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   logic [AW-3:0] wr_idx;
   logic [AW-3:0] rd_idx;
   logic wr_pending;
   logic wr_commit;
   logic wr_standby;
   logic wr_portgate;
   logic rd_pending;
   logic rd_monitor;
   logic rd_standby;
   logic rd_portgate;

   // word index; the low two address bits are ignored
   assign wr_idx = wr_addr[AW-1:2];
   assign rd_idx = rd_addr[AW-1:2];

   // stores need byte lane 0, the only lane holding register bits
   // a write without lane 0 still answers okay but stores nothing
   assign wr_pending = wr_fire & wr_lane0 & (wr_idx == (AW-2)'(`FCR_IDX_PENDING));
   assign wr_commit = wr_fire & wr_lane0 & (wr_idx == (AW-2)'(`FCR_IDX_COMMIT));
   assign wr_standby = wr_fire & wr_lane0 & (wr_idx == (AW-2)'(`FCR_IDX_STANDBY));
   assign wr_portgate = wr_fire & wr_lane0 & (wr_idx == (AW-2)'(`FCR_IDX_PORTGATE));

   // the commit address reads back the monitor
   assign rd_pending = (rd_idx == (AW-2)'(`FCR_IDX_PENDING));
   assign rd_monitor = (rd_idx == (AW-2)'(`FCR_IDX_MONITOR));
   assign rd_standby = (rd_idx == (AW-2)'(`FCR_IDX_STANDBY));
   assign rd_portgate = (rd_idx == (AW-2)'(`FCR_IDX_PORTGATE));

   // unmapped words answer slverr, mapped ones okay
   assign wr_err = ~((wr_idx == (AW-2)'(`FCR_IDX_PENDING)) |
                     (wr_idx == (AW-2)'(`FCR_IDX_COMMIT)) |
                     (wr_idx == (AW-2)'(`FCR_IDX_STANDBY)) |
                     (wr_idx == (AW-2)'(`FCR_IDX_PORTGATE)));
   assign rd_err = ~(rd_pending | rd_monitor | rd_standby | rd_portgate);

   // ----------------------------------------
   // operating mode
   // ----------------------------------------
   logic serial_mode_r;

   // mode sampled every cycle; held low during reset
   // one flop for the pin so every mode-dependent output moves in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_mode_r <= 1'b0;
      end else begin
         serial_mode_r <= serial_mode;
      end
   end

   // ----------------------------------------
   // pending and committed control
   // ----------------------------------------
   fcr_byte_t pending_r;
   fcr_byte_t shadow_r;
   logic key_hit;

   // only the exact key commits; any other byte at this address is a no-op
   assign key_hit = wr_commit & (wr_byte == `FCR_COMMIT_KEY);

   // software writes land only in the holding stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending_r <= `FCR_PENDING_RST;
      end else if (wr_pending) begin
         pending_r <= wr_byte;
      end
   end

   // key copies the whole pending byte in one step; other values ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shadow_r <= `FCR_PENDING_RST;
      end else if (key_hit) begin
         shadow_r <= pending_r;
      end
   end

   // ----------------------------------------
   // decoded mapping outputs
   // ----------------------------------------
   logic cmd_en_nxt;

   // only the exact enable code opens the array; reserved codes keep it shut
   assign cmd_en_nxt = (shadow_r[`FCR_MODE_HI:`FCR_MODE_LO] == FCR_CMD_ENABLE);

   // on a commit the enable follows the incoming code at once,
   // so the array state never lags the shadow by a cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flash_cmd_enable <= 1'b0;
      end else if (key_hit) begin
         flash_cmd_enable <= (pending_r[`FCR_MODE_HI:`FCR_MODE_LO] == FCR_CMD_ENABLE);
      end else begin
         flash_cmd_enable <= cmd_en_nxt;
      end
   end

   // boot rom forced visible in serial programming mode
   // the stored bit is kept, so leaving serial mode restores the software choice
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_rom_shown <= 1'b0;
      end else begin
         boot_rom_shown <= serial_mode_r | shadow_r[`FCR_BOOT_BIT];
      end
   end

   // remap only on the defined code; reserved codes behave as standard
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         area_remap <= 1'b0;
      end else begin
         area_remap <= (shadow_r[`FCR_AREA_HI:`FCR_AREA_LO] == FCR_AREA_CODE_TO_DATA);
      end
   end

   // spare field passed through from the shadow, no decode needed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         spare_select <= 2'h0;
      end else begin
         spare_select <= shadow_r[`FCR_SPARE_HI:`FCR_SPARE_LO];
      end
   end

   // ----------------------------------------
   // command strobe gating
   // ----------------------------------------
   // a strobe while disabled is simply dropped, never queued
   // queueing would let a late enable replay a stale command into the array
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_strobe_pass <= 1'b0;
      end else begin
         cmd_strobe_pass <= cmd_strobe & cmd_en_nxt;
      end
   end

   // ----------------------------------------
   // flash standby
   // ----------------------------------------
   // the vector-fetch clear outranks a software set in the same cycle,
   // since the flash vector read must never meet standby
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         standby_bit <= 1'b0;
      end else if (irq_taken && !vector_in_ram) begin
         standby_bit <= 1'b0;
      end else if (wr_standby && exec_from_ram) begin
         standby_bit <= wr_byte[`FCR_STANDBY_BIT];
      end
   end

   // one-cycle reset request on any flash touch during standby
   // the reset controller owns the rest; this block only flags the cause
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         standby_reset <= 1'b0;
      end else begin
         standby_reset <= flash_access & standby_bit;
      end
   end

   // ----------------------------------------
   // serial port input gating
   // ----------------------------------------
   logic [1:0] portgate_r;

   // stores only in serial mode; cpu-mode writes are lost
   // the register is inert in cpu mode; the last serial-mode value is kept
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         portgate_r <= 2'h0;
      end else if (wr_portgate && serial_mode_r) begin
         portgate_r <= wr_byte[`FCR_SCLK_GATE_BIT:`FCR_GEN_GATE_BIT];
      end
   end

   logic gate_r [0:1];

   // one flop per gate bit; cpu mode keeps every input enabled, so a
   // program that never touches the register still sees live pins
   for (genvar gi = 0; gi < 2; gi++) begin : g_gate
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            gate_r[gi] <= 1'b1;
         end else begin
            gate_r[gi] <= ~serial_mode_r | portgate_r[gi];
         end
      end
   end

   // each gate bit drives its own pin group
   assign serial_clock_input_gate = gate_r[`FCR_SCLK_GATE_BIT];
   assign general_port_input_gate = gate_r[`FCR_GEN_GATE_BIT];

   // ----------------------------------------
   // read data
   // ----------------------------------------
   fcr_byte_t monitor_val;

   // monitor shows the shadow; top two bits always zero
   // enable bit decodes the committed code, so a reserved code reads back as 0
   always_comb begin
      monitor_val = 8'h00;
      monitor_val[`FCR_MON_ENABLE_BIT] = cmd_en_nxt;
      monitor_val[`FCR_BOOT_BIT] = shadow_r[`FCR_BOOT_BIT] | serial_mode_r;
      monitor_val[`FCR_AREA_HI:`FCR_AREA_LO] = shadow_r[`FCR_AREA_HI:`FCR_AREA_LO];
      monitor_val[`FCR_SPARE_HI:`FCR_SPARE_LO] = shadow_r[`FCR_SPARE_HI:`FCR_SPARE_LO];
   end

   // standby reads all zero; port register zero in cpu mode
   // unmapped words also read zero; the bus flop adds the one cycle of latency
   always_comb begin
      rd_byte = 8'h00;
      if (rd_pending) begin
         rd_byte = pending_r;
      end else if (rd_monitor) begin
         rd_byte = monitor_val;
      end else if (rd_standby) begin
         rd_byte = 8'h00;
      end else if (rd_portgate && serial_mode_r) begin
         rd_byte = `FCR_PORTGATE_FIXED | {6'h00, portgate_r};
      end
   end

endmodule : fcr_top

// file: sim/fcr_chk.sv
`include "fcr_cfg.svh"

module fcr_chk #(
   parameter int AW = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic serial_mode,
   input wire logic exec_from_ram,
   input wire logic flash_access,
   input wire logic irq_taken,
   input wire logic vector_in_ram,
   input wire logic cmd_strobe,
   input wire logic cmd_strobe_pass,
   input wire logic flash_cmd_enable,
   input wire logic boot_rom_shown,
   input wire logic standby_bit,
   input wire logic standby_reset,
   input wire logic serial_clock_input_gate,
   input wire logic general_port_input_gate
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [AW-1:0] MON_A = AW'({`FCR_IDX_MONITOR, 2'b00});
   localparam logic [AW-1:0] STBY_A = AW'({`FCR_IDX_STANDBY, 2'b00});
   logic [1:0] up_cnt_r;
   logic [AW-1:0] rd_addr_r;

   // ----------------------------------------
   // helper state
   // ----------------------------------------
   // edges since release; mode checks wait for the mode input flop to settle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         up_cnt_r <= 2'h0;
      end else if (up_cnt_r != 2'h3) begin
         up_cnt_r <= up_cnt_r + 2'h1;
      end
   end

   // address of the read in flight
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         rd_addr_r <= s_axi_araddr;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ----------------------------------------
   // checks
   // ----------------------------------------
   cmd_pass_a: assert property (cmd_strobe && flash_cmd_enable |=> cmd_strobe_pass)
      else $error("strobe not passed while commands enabled");
   cmd_block_a: assert property (!(cmd_strobe && flash_cmd_enable) |=> !cmd_strobe_pass)
      else $error("strobe passed while commands disabled");
   stby_reset_a: assert property (flash_access && standby_bit |=> standby_reset)
      else $error("flash access in standby gave no reset");
   stby_quiet_a: assert property (!(flash_access && standby_bit) |=> !standby_reset)
      else $error("standby reset without cause");
   stby_write_a: assert property ($rose(standby_bit) |-> $past(exec_from_ram))
      else $error("standby set by code outside ram");
   stby_irq_a: assert property (irq_taken && !vector_in_ram |=> !standby_bit)
      else $error("flash vector did not clear standby");
   boot_serial_a: assert property (up_cnt_r == 2'h3 && $past(serial_mode) && $past(serial_mode, 2)
      |-> boot_rom_shown)
      else $error("boot rom hidden in serial mode");
   cpu_gates_a: assert property (up_cnt_r == 2'h3 && !$past(serial_mode) && !$past(serial_mode, 2)
      |-> serial_clock_input_gate && general_port_input_gate)
      else $error("port input gated in cpu mode");
   mon_read_a: assert property (s_axi_rvalid && rd_addr_r == MON_A |-> s_axi_rdata[7:6] == 2'h0)
      else $error("monitor top bits not zero");
   stby_read_a: assert property (s_axi_rvalid && rd_addr_r == STBY_A |-> s_axi_rdata == 32'h0)
      else $error("standby register read not zero");
endmodule : fcr_chk

bind fcr_top fcr_chk #(.AW(AW)) u_chk (.*);

// file: sim/fcr_tb_top.sv
`include "fcr_cfg.svh"

module fcr_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] PEND_A = {2'b00, `FCR_IDX_PENDING, 2'b00};
   localparam logic [15:0] MON_A = {2'b00, `FCR_IDX_MONITOR, 2'b00};
   localparam logic [15:0] STBY_A = {2'b00, `FCR_IDX_STANDBY, 2'b00};
   localparam logic [15:0] GATE_A = {2'b00, `FCR_IDX_PORTGATE, 2'b00};
   localparam logic [15:0] BAD_A = 16'h3F50;
   localparam logic [1:0] OK = `FCR_RESP_OKAY;
   logic aclk, aresetn;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, spare_select;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic serial_mode, exec_from_ram, flash_access, irq_taken, vector_in_ram, cmd_strobe;
   logic cmd_strobe_pass, flash_cmd_enable, boot_rom_shown, area_remap, standby_bit, standby_reset;
   logic serial_clock_input_gate, general_port_input_gate;
   int fails, compares;

   fcr_top #(.AW(16)) u_dut (.*);

   always #20 aclk = ~aclk;

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick

   // address and data offered together, bready held until the answer
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er, "write response");
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic [1:0] er, input string what);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rresp, er, what);
      chk(s_axi_rdata, {24'h0, exp}, what);
   endtask : rd

   // one-cycle pulse of {cmd_strobe, flash_access, irq_taken}; returns when its effect shows
   task automatic pulse(input logic [2:0] sel);
      @(posedge aclk);
      {cmd_strobe, flash_access, irq_taken} <= sel;
      @(posedge aclk);
      {cmd_strobe, flash_access, irq_taken} <= 3'b000;
      @(posedge aclk);
   endtask : pulse

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      rd(PEND_A, 8'h40, OK, "pending after reset");
      rd(MON_A, 8'h00, OK, "monitor after reset");
      rd(STBY_A, 8'h00, OK, "standby after reset");
      rd(GATE_A, 8'h00, OK, "port gate in cpu mode");
      rd(BAD_A, 8'h00, `FCR_RESP_SLVERR, "unmapped read");
      wr(BAD_A, 8'hFF, `FCR_RESP_SLVERR);
      chk(flash_cmd_enable, 1'b0, "commands off after reset");
      chk({serial_clock_input_gate, general_port_input_gate}, 2'b11, "gates open");
      $display("test reset done");
   endtask : t_reset

   // pending value is held until the key; a wrong key changes nothing
   task automatic t_commit;
      wr(PEND_A, 8'hBB, OK);
      rd(PEND_A, 8'hBB, OK, "pending holds write");
      rd(MON_A, 8'h00, OK, "shadow untouched");
      wr(MON_A, 8'hD4, OK);
      rd(MON_A, 8'h00, OK, "wrong key ignored");
      rd(PEND_A, 8'hBB, OK, "pending kept");
      wr(MON_A, `FCR_COMMIT_KEY, OK);
      rd(MON_A, 8'h3B, OK, "monitor shows commit");
      chk({flash_cmd_enable, boot_rom_shown, area_remap, spare_select}, 5'h1F, "enabled outputs");
      pulse(3'b100);
      chk(cmd_strobe_pass, 1'b1, "strobe passes");
      wr(PEND_A, 8'h40, OK);
      wr(MON_A, `FCR_COMMIT_KEY, OK);
      rd(MON_A, 8'h00, OK, "monitor disabled");
      chk({flash_cmd_enable, boot_rom_shown, area_remap, spare_select}, 5'h00, "disabled outputs");
      pulse(3'b100);
      chk(cmd_strobe_pass, 1'b0, "strobe blocked");
      $display("test commit done");
   endtask : t_commit

   task automatic t_standby;
      exec_from_ram <= 1'b0;
      wr(STBY_A, 8'h01, OK);
      chk(standby_bit, 1'b0, "flash code write dropped");
      exec_from_ram <= 1'b1;
      wr(STBY_A, 8'h01, OK);
      chk(standby_bit, 1'b1, "ram code write taken");
      rd(STBY_A, 8'h00, OK, "standby reads zero");
      pulse(3'b010);
      chk(standby_reset, 1'b1, "standby reset raised");
      vector_in_ram <= 1'b1;
      pulse(3'b001);
      chk(standby_bit, 1'b1, "ram vector keeps bit");
      vector_in_ram <= 1'b0;
      pulse(3'b001);
      chk(standby_bit, 1'b0, "flash vector clears bit");
      pulse(3'b010);
      chk(standby_reset, 1'b0, "no reset out of standby");
      $display("test standby done");
   endtask : t_standby

   // mode input lags two edges, hence the settling ticks
   task automatic t_serial;
      serial_mode <= 1'b1;
      tick(3);
      chk({boot_rom_shown, serial_clock_input_gate, general_port_input_gate}, 3'b100, "serial entry");
      rd(MON_A, 8'h10, OK, "boot status forced");
      rd(GATE_A, 8'h80, OK, "gate reset value");
      wr(GATE_A, 8'h02, OK);
      tick(1);
      chk({serial_clock_input_gate, general_port_input_gate}, 2'b10, "clock pin only");
      wr(GATE_A, 8'h01, OK);
      tick(1);
      chk({serial_clock_input_gate, general_port_input_gate}, 2'b01, "general ports only");
      rd(GATE_A, 8'h81, OK, "gate read back");
      serial_mode <= 1'b0;
      wr(GATE_A, 8'h02, OK);
      tick(1);
      chk({boot_rom_shown, serial_clock_input_gate, general_port_input_gate}, 3'b011, "cpu mode");
      rd(GATE_A, 8'h00, OK, "gate reads zero");
      serial_mode <= 1'b1;
      tick(3);
      rd(GATE_A, 8'h81, OK, "cpu write discarded");
      serial_mode <= 1'b0;
      tick(3);
      $display("test serial done");
   endtask : t_serial

   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic conclude;
      $display("counts: compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      {serial_mode, exec_from_ram, flash_access, irq_taken, vector_in_ram, cmd_strobe} = '0;
      fails = 0;
      compares = 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_commit;
      t_standby;
      t_serial;
      conclude;
   end

   // the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge aclk);
      fails++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      conclude;
   end
endmodule : fcr_tb_top
